// File: rtl/ipvb_arbiter.sv
// Picks the highest-level enabled pending source, lowest index on ties
module ipvb_arbiter
    import ipvb_pkg::*;
#(
    parameter int N_SRC = 14
)
(
    input wire logic [N_SRC-1:0] req,
    input wire logic [1:0] field [N_SRC],
    output ipvb_win_s win
);

    // ==========================================================
    // Scan in fixed index order; only a strictly higher level replaces
    always_comb
    begin
        logic [2:0] dec;
        dec = '0;
        win = '0;
        for (int i = 0; i < N_SRC; i++)
        begin
            dec = ipvb_decode(field[i]);
            if (req[i] && dec[2] && (!win.valid || dec[1:0] > win.level))
            begin
                win.valid = 1'b1;
                win.level = dec[1:0];
                win.idx = 4'(i);
            end
        end
    end

endmodule // ipvb_arbiter

// File: rtl/ipvb_defines.svh
// Constants for the interrupt priority and vector base block
`ifndef IPVB_DEFINES_SVH
`define IPVB_DEFINES_SVH

// ==========================================================
// Register indexes and their byte addresses (index times four)
`define IPVB_IDX_TC 8'h05
`define IPVB_IDX_PC 8'h06
`define IPVB_IDX_VB 8'h07
`define IPVB_ADDR_TC (`IPVB_IDX_TC << 2)
`define IPVB_ADDR_PC (`IPVB_IDX_PC << 2)
`define IPVB_ADDR_VB (`IPVB_IDX_VB << 2)

// ==========================================================
// Field positions, timers and comparators register
`define IPVB_PIT1_LSB 14
`define IPVB_PIT0_LSB 12
`define IPVB_COMPB_LSB 10
`define IPVB_COMPA_LSB 8
`define IPVB_TMRB3_LSB 6
`define IPVB_TMRB2_LSB 4
`define IPVB_TMRB1_LSB 2
`define IPVB_TMRB0_LSB 0

// ==========================================================
// Field positions, pwm and converters register
`define IPVB_PWMF_LSB 10
`define IPVB_PWMRL_LSB 8
`define IPVB_ADCZC_LSB 6
`define IPVB_ADCB_LSB 4
`define IPVB_ADCA_LSB 2
`define IPVB_PIT2_LSB 0

// ==========================================================
// Widths, reset values and other constants
`define IPVB_PC_W 12
`define IPVB_VB_W 14
`define IPVB_IDX_W 7
`define IPVB_TC_RST 16'h0000
`define IPVB_PC_RST 12'h000
`define IPVB_VB_RST_A 14'h0000
`define IPVB_VB_RST_B 14'h0080
`define IPVB_FIELD_OFF 2'h0
`define IPVB_LVL_MAX 2'h2
`define IPVB_VEC_FIRST 7'h20
`define IPVB_HRESP_OKAY 1'b0

`endif

// File: rtl/ipvb_pkg.sv
// Types and shared functions of the interrupt priority and vector block
package ipvb_pkg;

    // One-hot register select
    typedef enum logic [3:0] {
        IPVB_SEL_NONE = 4'b0001,
        IPVB_SEL_TC = 4'b0010,
        IPVB_SEL_PC = 4'b0100,
        IPVB_SEL_VB = 4'b1000
    } ipvb_sel_e;

    // Captured bus address phase
    typedef struct packed {
        logic valid;
        logic write;
        ipvb_sel_e sel;
    } ipvb_aphase_s;

    // Arbitration winner
    typedef struct packed {
        logic valid;
        logic [1:0] level;
        logic [3:0] idx;
    } ipvb_win_s;

    // Field to {enabled, level}: 00 off, 01..11 give levels 0..2
    function automatic logic [2:0] ipvb_decode(input logic [1:0] f);
        return {f != 2'h0, 2'(f - 2'h1)};
    endfunction

endpackage

// File: rtl/ipvb_top.sv
// Interrupt priority registers, vector base and vector address output
`include "ipvb_defines.svh"

module ipvb_top
    import ipvb_pkg::*;
#(
    parameter bit VARIANT_B = 1'b0,
    parameter int N_SRC = 14
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [N_SRC-1:0] irq_req,
    output logic irq_valid_out,
    output logic [1:0] irq_level_out,
    output logic [20:0] vector_address_out
);

    // ==========================================================
    // Reset release through two flip-flops
    logic rst_meta;
    logic rst_sync;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ==========================================================
    // Address phase decode
    localparam logic [13:0] VB_RST =
        VARIANT_B ? `IPVB_VB_RST_B : `IPVB_VB_RST_A;

    logic [15:0] tc;
    logic [`IPVB_PC_W-1:0] pc;
    logic [`IPVB_VB_W-1:0] vb;
    ipvb_aphase_s ap;
    ipvb_aphase_s next_ap;
    logic [31:0] next_hrdata;

    wire xfer = hsel && htrans[1] && hready;
    wire upper_zero = haddr[31:8] == 24'h0;
    wire hit_tc = upper_zero && haddr[7:0] == `IPVB_ADDR_TC;
    wire hit_pc = upper_zero && haddr[7:0] == `IPVB_ADDR_PC;
    wire hit_vb = upper_zero && haddr[7:0] == `IPVB_ADDR_VB;
    ipvb_sel_e addr_sel;

    always_comb
    begin
        if (hit_tc)
            addr_sel = IPVB_SEL_TC;
        else if (hit_pc)
            addr_sel = IPVB_SEL_PC;
        else if (hit_vb)
            addr_sel = IPVB_SEL_VB;
        else
            addr_sel = IPVB_SEL_NONE;
    end

    assign next_ap = '{valid: xfer, write: hwrite, sel: addr_sel};

    // ==========================================================
    // Data phase write; reserved bits never stored
    wire wr_now = ap.valid && ap.write;
    wire wr_tc = wr_now && ap.sel == IPVB_SEL_TC;
    wire wr_pc = wr_now && ap.sel == IPVB_SEL_PC;
    wire wr_vb = wr_now && ap.sel == IPVB_SEL_VB;

    always_ff @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            ap <= '{valid: 1'b0, write: 1'b0, sel: IPVB_SEL_NONE};
            tc <= `IPVB_TC_RST;
            pc <= `IPVB_PC_RST;
            vb <= VB_RST;
        end
        else if (ce)
        begin
            ap <= next_ap;
            if (wr_tc)
                tc <= hwdata[15:0];
            if (wr_pc)
                pc <= hwdata[`IPVB_PC_W-1:0];
            if (wr_vb)
                vb <= hwdata[`IPVB_VB_W-1:0];
        end
    end

    // ==========================================================
    // Read data, taken in the address phase, forwarding a write
    // that is in its data phase to the same register
    wire [15:0] tc_view = wr_tc ? hwdata[15:0] : tc;
    wire [`IPVB_PC_W-1:0] pc_view =
        wr_pc ? hwdata[`IPVB_PC_W-1:0] : pc;
    wire [`IPVB_VB_W-1:0] vb_view =
        wr_vb ? hwdata[`IPVB_VB_W-1:0] : vb;

    always_comb
    begin
        if (addr_sel == IPVB_SEL_TC)
            next_hrdata = {16'h0, tc_view};
        else if (addr_sel == IPVB_SEL_PC)
            next_hrdata = {20'h0, pc_view};
        else if (addr_sel == IPVB_SEL_VB)
            next_hrdata = {18'h0, vb_view};
        else
            next_hrdata = 32'h0;
    end

    always_ff @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= `IPVB_HRESP_OKAY;
        end
        else if (ce && xfer && !hwrite)
            hrdata <= next_hrdata;
    end

    // ==========================================================
    // Per-source priority fields, in tie-break order
    logic [1:0] src_field [N_SRC];

    assign src_field[0] = tc[`IPVB_TMRB0_LSB +: 2];
    assign src_field[1] = tc[`IPVB_TMRB1_LSB +: 2];
    assign src_field[2] = tc[`IPVB_TMRB2_LSB +: 2];
    assign src_field[3] = tc[`IPVB_TMRB3_LSB +: 2];
    assign src_field[4] = tc[`IPVB_COMPA_LSB +: 2];
    assign src_field[5] = tc[`IPVB_COMPB_LSB +: 2];
    assign src_field[6] = tc[`IPVB_PIT0_LSB +: 2];
    assign src_field[7] = tc[`IPVB_PIT1_LSB +: 2];
    assign src_field[8] = pc[`IPVB_PIT2_LSB +: 2];
    assign src_field[9] = pc[`IPVB_ADCA_LSB +: 2];
    assign src_field[10] = pc[`IPVB_ADCB_LSB +: 2];
    assign src_field[11] = pc[`IPVB_ADCZC_LSB +: 2];
    assign src_field[12] = pc[`IPVB_PWMRL_LSB +: 2];
    assign src_field[13] = pc[`IPVB_PWMF_LSB +: 2];

    // ==========================================================
    // Arbitration and vector formation
    ipvb_win_s win;

    ipvb_arbiter #(
        .N_SRC(N_SRC)
    ) u_arbiter (
        .req(irq_req),
        .field(src_field),
        .win(win)
    );

    wire [`IPVB_IDX_W-1:0] win_vec =
        `IPVB_IDX_W'(`IPVB_VEC_FIRST + `IPVB_IDX_W'(win.idx));

    always_ff @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            irq_valid_out <= 1'b0;
            irq_level_out <= 2'h0;
            vector_address_out <= 21'h0;
        end
        else if (ce)
        begin
            irq_valid_out <= win.valid;
            irq_level_out <= win.level;
            vector_address_out <= {vb, win_vec};
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_sync);

    logic [1:0] max_lvl;
    logic [2:0] win_dec;

    always_comb
    begin
        logic [2:0] d;
        d = '0;
        max_lvl = 2'h0;
        for (int i = 0; i < N_SRC; i++)
        begin
            d = ipvb_decode(src_field[i]);
            if (irq_req[i] && d[2] && d[1:0] > max_lvl)
                max_lvl = d[1:0];
        end
    end

    assign win_dec = ipvb_decode(src_field[win.idx]);

    sequence s_wr_tc;
        ce && wr_tc;
    endsequence

    sequence s_wr_pc;
        ce && wr_pc;
    endsequence

    sequence s_rd(ipvb_sel_e s);
        ce && xfer && !hwrite && addr_sel == s;
    endsequence

    property p_field_decode;
        win.valid |-> src_field[win.idx] != `IPVB_FIELD_OFF
            && win.level == 2'(src_field[win.idx] - 2'h1);
    endproperty
    a_field_decode: assert property (p_field_decode)
        else $error("winner level does not match its field");

    property p_level_cap;
        irq_level_out <= `IPVB_LVL_MAX && win.level <= `IPVB_LVL_MAX;
    endproperty
    a_level_cap: assert property (p_level_cap)
        else $error("priority level above two");

    property p_pit_fields;
        s_wr_tc |=> tc[15:12] == $past(hwdata[15:12])
            && (win_dec[2] || !win.valid);
    endproperty
    a_pit_fields: assert property (p_pit_fields)
        else $error("interval timer fields not written");

    property p_cmp_fields;
        s_wr_tc |=> tc[11:8] == $past(hwdata[11:8]);
    endproperty
    a_cmp_fields: assert property (p_cmp_fields)
        else $error("comparator fields not written");

    property p_tmrb_fields;
        s_wr_tc |=> src_field[3] == $past(hwdata[7:6])
            && src_field[0] == $past(hwdata[1:0]);
    endproperty
    a_tmrb_fields: assert property (p_tmrb_fields)
        else $error("timer B fields misplaced");

    property p_pwm_fields;
        s_wr_pc |=> src_field[13] == $past(hwdata[11:10])
            && src_field[12] == $past(hwdata[9:8]);
    endproperty
    a_pwm_fields: assert property (p_pwm_fields)
        else $error("pwm fields misplaced");

    property p_adc_fields;
        s_wr_pc |=> src_field[11] == $past(hwdata[7:6])
            && src_field[10] == $past(hwdata[5:4])
            && src_field[9] == $past(hwdata[3:2]);
    endproperty
    a_adc_fields: assert property (p_adc_fields)
        else $error("converter fields misplaced");

    property p_pit2_field;
        s_wr_pc |=> src_field[8] == $past(hwdata[1:0]);
    endproperty
    a_pit2_field: assert property (p_pit2_field)
        else $error("interval timer 2 field misplaced");

    property p_reserved_zero;
        s_rd(IPVB_SEL_PC) |=> hrdata[31:12] == 20'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits of second register not zero");

    property p_vb_reserved;
        s_rd(IPVB_SEL_VB) |=> hrdata[31:14] == 18'h0;
    endproperty
    a_vb_reserved: assert property (p_vb_reserved)
        else $error("reserved bits of vector base not zero");

    property p_reset_values;
        $rose(rst_sync) |-> tc == `IPVB_TC_RST && pc == `IPVB_PC_RST
            && vb == VB_RST;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("wrong value after reset");

    property p_vector_form;
        ce && win.valid |=> irq_valid_out
            && vector_address_out == {$past(vb), $past(win_vec)};
    endproperty
    a_vector_form: assert property (p_vector_form)
        else $error("vector address not formed from base and index");

    property p_highest_wins;
        win.valid |-> win.level == max_lvl;
    endproperty
    a_highest_wins: assert property (p_highest_wins)
        else $error("winner is not of the highest level");

    // Zero wait states and an OKAY answer on every cycle
    property p_bus_okay;
        hreadyout && hresp == `IPVB_HRESP_OKAY;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus response not ready and okay");

    property p_unmapped_read;
        s_rd(IPVB_SEL_NONE) |=> hrdata == 32'h0;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped address did not read zero");

    // Clock enable low freezes registers and outputs
    property p_ce_freeze;
        !ce |=> $stable(tc) && $stable(pc) && $stable(vb)
            && $stable(vector_address_out) && $stable(hrdata);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state changed while clock enable low");

endmodule // ipvb_top

// File: verification/ipvb_core_model.sv
// Processor core model that takes vector addresses from the block
module ipvb_core_model
    import ipvb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic irq_valid,
    input wire logic [1:0] irq_level,
    input wire logic [20:0] vector_address,
    output logic [20:0] taken_vector,
    output logic level_fault
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Vector fetch
    // The core latches the vector of every cycle with ce high that offers one
    // and flags any level outside the three usable ones
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            taken_vector <= 21'h000000;
            level_fault <= 1'b0;
        end
        else if (ce && irq_valid)
        begin
            taken_vector <= vector_address;
            if (irq_level > 2'h2)
            begin
                level_fault <= 1'b1;
            end
        end
    end
endmodule // ipvb_core_model

// File: verification/irq_priority_vector_base_tb.sv
// Self-checking testbench of the interrupt priority and vector block
`include "ipvb_defines.svh"

module irq_priority_vector_base_tb
    import ipvb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam bit VAR_B = 1'b1;
    localparam logic [13:0] RST_BASE = VAR_B ? `IPVB_VB_RST_B : `IPVB_VB_RST_A;
    localparam logic [13:0] NEW_BASE = 14'h2A5C;
    logic ref_clk, rst_n, ce, hsel, hwrite, hreadyout, hresp;
    logic irq_valid_out, level_fault;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, irq_level_out;
    logic [2:0] hsize;
    logic [13:0] irq_req;
    logic [20:0] vector_address_out, taken_vector;
    int miscompares = 0;
    int tests_run = 0;

    ipvb_top #(.VARIANT_B(VAR_B), .N_SRC(14)) u_ipvb_top
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req),
        .irq_valid_out(irq_valid_out), .irq_level_out(irq_level_out),
        .vector_address_out(vector_address_out)
    );

    ipvb_core_model u_ipvb_core_model
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .irq_valid(irq_valid_out), .irq_level(irq_level_out),
        .vector_address(vector_address_out),
        .taken_vector(taken_vector), .level_fault(level_fault)
    );

    // ==========================================================
    // Clock and watchdog
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial
    begin
        #(40 * 5000);
        miscompares++;
        summarize();
    end

    // ==========================================================
    // Bus and compare tasks
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 50)
        begin
            miscompares++;
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
                         input logic [31:0] exp);
        bus(1'b1, a, d, rd);
        bus(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        irq_req = 14'h0000;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // Every source requests while all fields hold their reset value
        irq_req <= 14'h3FFF;
        bus(1'b0, `IPVB_ADDR_TC, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b0, `IPVB_ADDR_PC, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b0, `IPVB_ADDR_VB, 32'h0, rd);
        check(rd, 32'(RST_BASE));
        check(32'(irq_valid_out), 32'h0);
        bus(1'b1, `IPVB_ADDR_TC, 32'h1, rd);
        repeat (2) @(posedge ref_clk);
        check(32'(vector_address_out),
              32'({RST_BASE, `IPVB_VEC_FIRST}));
        irq_req <= 14'h0000;
        $display("reset test done");
        wr_rd(`IPVB_ADDR_TC, 32'hFFFFFFFF, 32'h0000FFFF);
        wr_rd(`IPVB_ADDR_PC, 32'h00000FFF, 32'h00000FFF);
        wr_rd(`IPVB_ADDR_VB, 32'h00003FFF, 32'h00003FFF);
        wr_rd(8'h20, 32'hFFFFFFFF, 32'h0);
        wr_rd(`IPVB_ADDR_VB, 32'(NEW_BASE), 32'(NEW_BASE));
        $display("access test done");
        // One source at a time, every field code
        for (int k = 0; k < 14; k++)
        begin
            for (int f = 0; f < 4; f++)
            begin
                irq_req <= 14'h1 << k;
                bus(1'b1, k < 8 ? `IPVB_ADDR_TC : `IPVB_ADDR_PC,
                    32'(f) << (2 * (k % 8)), rd);
                repeat (2) @(posedge ref_clk);
                check(32'(irq_valid_out), 32'(f != 0));
                if (f != 0)
                begin
                    check(32'(irq_level_out), 32'(f - 1));
                    check(32'(vector_address_out),
                          32'({NEW_BASE, 7'(`IPVB_VEC_FIRST + k)}));
                end
            end
        end
        $display("field test done");
        // Sources 1, 5 and 13 share the top level; source 0 is lower
        irq_req <= 14'h2023;
        bus(1'b1, `IPVB_ADDR_TC, 32'h0C0E, rd);
        bus(1'b1, `IPVB_ADDR_PC, 32'h0C00, rd);
        repeat (2) @(posedge ref_clk);
        check(32'(irq_level_out), 32'h2);
        check(32'(vector_address_out), 32'({NEW_BASE, 7'h21}));
        irq_req <= 14'h2021;
        repeat (2) @(posedge ref_clk);
        check(32'(vector_address_out), 32'({NEW_BASE, 7'h25}));
        // The core latches the vector one edge after it appears
        @(posedge ref_clk);
        check(32'(taken_vector), 32'({NEW_BASE, 7'h25}));
        check(32'(level_fault), 32'h0);
        $display("priority test done");
        // Clock enable low holds the old vector; source 0 wins after
        ce <= 1'b0;
        irq_req <= 14'h0001;
        repeat (3) @(posedge ref_clk);
        check(32'(vector_address_out), 32'({NEW_BASE, 7'h25}));
        ce <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check(32'(vector_address_out), 32'({NEW_BASE, 7'h20}));
        check(32'(irq_level_out), 32'h1);
        $display("enable test done");
        summarize();
    end
endmodule // irq_priority_vector_base_tb
